// file: fbc_consts.svh
// timing and field constants for the flash bus host controller
`ifndef FBC_CONSTS_SVH
`define FBC_CONSTS_SVH
`define FBC_CLK_PERIOD_NS 8
`define FBC_ACCESS_TIME_NS 70
`define FBC_CE_ACCESS_TIME_NS 70
`define FBC_WRITE_PULSE_NS 35
`define FBC_WRITE_HOLD_NS 30
`define FBC_CLEAR_PULSE_MIN_TIME_NS 500
`define FBC_CLEAR_RECOVERY_TIME_NS 50
`define FBC_READY_WAIT_NS 20000
`define FBC_CMD_ADDR_A 12'h555
`define FBC_CMD_ADDR_B 12'h2AA
`define FBC_CMD_UNLOCK_A 16'h00AA
`define FBC_CMD_UNLOCK_B 16'h0055
`define FBC_CMD_PROGRAM 16'h00A0
`define FBC_CNT_W 16
`endif

// file: fbc_flash_model.sv
// behavioural flash device facing the host controller
`timescale 1ns/1ns
module fbc_flash_model (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_n,
  input wire logic [21:0] addr,
  input wire logic wbs,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic ready_busy_n
);
  logic [15:0] mem [0:15];
  logic [15:0] last_cmd = 16'h0000;
  logic [15:0] last_out = 16'h0000;
  logic [7:0] busy_cnt = 8'h00;
  logic we_q = 1'b1;
  // reads are served while busy, as from another bank or a suspended erase
  // only low address bits decode here; bank, sector and id decode are not modelled
  // data follows the address combinationally, so stable addresses keep output valid
  wire [15:0] word = mem[addr[3:0]];
  wire drive = !ce_n && !oe_n && we_n && reset_n;
  wire wr_ok = !ce_n && oe_n && reset_n;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hC350 ^ 16'(i);
  // released lines show the inverse of the last value, never a stale match
  assign dout = drive ? (wbs ? word : {~last_out[15:8], word[7:0]}) : ~last_out;
  assign ready_busy_n = busy_cnt == 8'h00;
  always @(posedge clk) begin
    we_q <= we_n;
    last_out <= dout;
    // busy runs on through deselect and reset
    if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
    if (we_n && !we_q && wr_ok) begin
      // program data follows the program code in both sequences
      if (last_cmd == 16'h00A0) begin
        mem[addr[3:0]] <= din;
        busy_cnt <= 8'h28;
      end
      last_cmd <= din;
    end
    if (!reset_n) last_cmd <= 16'h0000;
  end
endmodule

// file: fbc_host.sv
// host-side bus controller for a multi-bank parallel nor flash
`timescale 1ns/1ns
`include "fbc_consts.svh"
// Overview of operation
// - reads drive chip-enable and output-enable low, write-enable high, then sample data
// - commands drive write-enable and chip-enable low with output-enable high
// - shortcut mode programs with two writes instead of four
// - high voltage only for accelerated programming; input never floats (the code also holds it high for one cycle as the next request starts)
// - allow full chip-enable access time before trusting read data
// - restart any operation cut off by a hardware reset; this module leaves that to the caller
// - wait reset recovery time after reset release before reading
module fbc_host
  import fbc_pkg::*;
#(
  parameter int ADDR_W = 22,
  parameter int READY_WAIT_NS = `FBC_READY_WAIT_NS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire fbc_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic req_word_mode,
  input wire logic req_accel,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_timeout,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic word_byte_select,
  output logic protect_accelerate_in,
  output logic high_program_voltage,
  output logic [15:0] data_lines_out,
  output logic data_lines_oe,
  output logic addr_lsb_out,
  input wire logic [15:0] data_lines_in,
  input wire logic ready_busy_n
);
  localparam int CNT_W = `FBC_CNT_W;
  localparam int RD_CYC = (`FBC_CE_ACCESS_TIME_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS;
  localparam int WP_CYC = (`FBC_WRITE_PULSE_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS;
  localparam int WH_CYC = (`FBC_WRITE_HOLD_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS;
  localparam int RP_CYC =
    (`FBC_CLEAR_PULSE_MIN_TIME_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS;
  localparam int RH_CYC =
    (`FBC_CLEAR_RECOVERY_TIME_NS + `FBC_CLK_PERIOD_NS - 1) / `FBC_CLK_PERIOD_NS;
  localparam int RDY_CYC = READY_WAIT_NS / `FBC_CLK_PERIOD_NS;

  fbc_state_t state_reg;
  fbc_state_t state_next;
  fbc_op_t op_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [1:0] step_reg;
  logic [15:0] wdata_reg;
  // target address kept apart from the pins, which carry the unlock addresses meanwhile
  logic [ADDR_W-1:0] addr_reg;
  logic accel_reg;
  logic rb_sync;
  logic ce_n_next;
  logic oe_n_next;
  logic we_n_next;
  logic rst_n_next;
  logic [ADDR_W-1:0] addr_next;
  logic [15:0] dout_next;
  logic doe_next;
  logic [15:0] rdata_sel;
  logic cnt_zero;
  logic last_step;

  // ready_busy_n is a device pin, so it passes three synchroniser flops and a filter flop
  fbc_sync3 #(.INIT(1'b1)) u_rb_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(ready_busy_n),
    .dout(rb_sync)
  );

  assign cnt_zero = (cnt_reg == '0);
  // shortcut programming needs two writes, normal programming four
  assign last_step = (op_reg != FBC_OP_PROGRAM) || (accel_reg ? (step_reg == 2'd1) :
    (step_reg == 2'd3));
  // byte mode keeps only the low eight lines
  assign rdata_sel = word_byte_select ? data_lines_in : {8'h00, data_lines_in[7:0]};

  // program sequence: unlock pair, program code, data; shortcut skips the unlock pair
  logic [1:0] eff_step;
  assign eff_step = accel_reg ? (step_reg + 2'd2) : step_reg;
  assign addr_next = (op_reg != FBC_OP_PROGRAM || eff_step == 2'd3) ? addr_reg :
    (eff_step == 2'd1) ? ADDR_W'(`FBC_CMD_ADDR_B) : ADDR_W'(`FBC_CMD_ADDR_A);
  assign dout_next = (op_reg != FBC_OP_PROGRAM || eff_step == 2'd3) ? wdata_reg :
    (eff_step == 2'd0) ? `FBC_CMD_UNLOCK_A :
    (eff_step == 2'd1) ? `FBC_CMD_UNLOCK_B : `FBC_CMD_PROGRAM;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
    ce_n_next = 1'b1;
    oe_n_next = 1'b1;
    we_n_next = 1'b1;
    rst_n_next = 1'b1;
    doe_next = 1'b0;
    case (state_reg)
      FBC_IDLE: begin
        if (req_valid) begin
          case (req_op)
            FBC_OP_READ: state_next = FBC_RD_SETUP;
            FBC_OP_RESET: state_next = FBC_RST_PULSE;
            default: state_next = FBC_WR_SETUP;
          endcase
          cnt_next = CNT_W'(RP_CYC);
        end
      end
      FBC_RD_SETUP: begin
        // chip-enable and output-enable low, write-enable high
        ce_n_next = 1'b0;
        oe_n_next = 1'b0;
        cnt_next = CNT_W'(RD_CYC);
        state_next = FBC_RD_WAIT;
      end
      FBC_RD_WAIT: begin
        ce_n_next = 1'b0;
        oe_n_next = 1'b0;
        // full chip-enable access time before sampling
        if (cnt_zero) begin
          state_next = FBC_DONE;
          ce_n_next = 1'b1;
          oe_n_next = 1'b1;
        end
      end
      FBC_WR_SETUP: begin
        // write-enable and chip-enable low, output-enable high
        ce_n_next = 1'b0;
        doe_next = 1'b1;
        we_n_next = 1'b0;
        cnt_next = CNT_W'(WP_CYC);
        state_next = FBC_WR_PULSE;
      end
      FBC_WR_PULSE: begin
        ce_n_next = 1'b0;
        doe_next = 1'b1;
        we_n_next = 1'b0;
        if (cnt_zero) begin
          we_n_next = 1'b1;
          cnt_next = CNT_W'(WH_CYC);
          state_next = FBC_WR_HOLD;
        end
      end
      FBC_WR_HOLD: begin
        doe_next = 1'b1;
        if (cnt_zero) begin
          state_next = last_step ? FBC_DONE : FBC_WR_SETUP;
          doe_next = ~last_step;
        end
      end
      FBC_RST_PULSE: begin
        // hold reset low for the minimum pulse time
        rst_n_next = 1'b0;
        if (cnt_zero) begin
          rst_n_next = 1'b1;
          cnt_next = CNT_W'(RH_CYC + RDY_CYC);
          state_next = FBC_RST_RECOVER;
        end
      end
      FBC_RST_RECOVER: begin
        // wait recovery and for ready_busy_n to return, bounded
        // the caller reissues any cut-off operation once this ends
        if (cnt_reg <= CNT_W'(RDY_CYC) && rb_sync) begin
          state_next = FBC_DONE;
        end else if (cnt_zero) begin
          state_next = FBC_DONE;
        end
      end
      FBC_DONE: state_next = FBC_IDLE;
      default: state_next = FBC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= FBC_IDLE;
      cnt_reg <= '0;
      op_reg <= FBC_OP_READ;
      step_reg <= 2'd0;
      wdata_reg <= 16'h0000;
      addr_reg <= '0;
      accel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == FBC_IDLE && req_valid) begin
        op_reg <= req_op;
        wdata_reg <= req_wdata;
        addr_reg <= req_addr;
        accel_reg <= req_accel && (req_op == FBC_OP_PROGRAM);
        step_reg <= 2'd0;
      end else if (state_reg == FBC_WR_HOLD && cnt_zero && !last_step) begin
        step_reg <= step_reg + 2'd1;
      end
    end
  end

  // pin outputs all registered; bus idles deselected, which is standby
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_reset_n <= 1'b1;
      flash_addr <= '0;
      word_byte_select <= 1'b1;
      protect_accelerate_in <= 1'b1;
      high_program_voltage <= 1'b0;
      data_lines_out <= 16'h0000;
      data_lines_oe <= 1'b0;
      addr_lsb_out <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      rsp_timeout <= 1'b0;
    end else begin
      flash_ce_n <= ce_n_next;
      flash_oe_n <= oe_n_next;
      flash_we_n <= we_n_next;
      flash_reset_n <= rst_n_next;
      req_ready <= (state_next == FBC_IDLE);
      rsp_valid <= (state_reg == FBC_DONE);
      if (state_reg == FBC_IDLE && req_valid) begin
        flash_addr <= req_addr;
        word_byte_select <= req_word_mode;
        addr_lsb_out <= req_addr[0];
        rsp_timeout <= 1'b0;
      end else if (state_reg == FBC_WR_SETUP) begin
        flash_addr <= addr_next;
        data_lines_out <= word_byte_select ? dout_next : {8'h00, dout_next[7:0]};
      end
      data_lines_oe <= doe_next;
      // high voltage while an accelerated program runs and for one cycle as the next request starts, as accel_reg holds till then; pin never floats
      high_program_voltage <= accel_reg && state_next != FBC_IDLE && state_next != FBC_DONE;
      if (state_reg == FBC_RD_WAIT && cnt_zero) begin
        rsp_rdata <= rdata_sel;
      end
      if (state_reg == FBC_RST_RECOVER && cnt_zero && !rb_sync) begin
        rsp_timeout <= 1'b1;
      end
    end
  end
endmodule

// file: fbc_host_assertions.sv
// bus timing checks on the flash host controller pins
`timescale 1ns/1ns
module fbc_host_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rsp_valid,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_reset_n,
  input wire logic protect_accelerate_in,
  input wire logic high_program_voltage,
  input wire logic data_lines_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] low_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) low_cnt <= 8'h00;
    else if (flash_reset_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  a_read_ctrl: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n)
    else $error("read strobes wrong");
  a_no_fight: assert property (!flash_oe_n |-> !data_lines_oe)
    else $error("host drives during read");
  a_write_ctrl: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && data_lines_oe)
    else $error("write strobes wrong");
  a_prot_high: assert property (protect_accelerate_in)
    else $error("protect input not high");
  a_hv_no_read: assert property (high_program_voltage |-> flash_oe_n)
    else $error("read under high voltage");
  a_oe_hold: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8])
    else $error("read too short");
  a_reset_width: assert property ($rose(flash_reset_n) |-> low_cnt >= 8'h3E)
    else $error("reset pulse too short");
  a_recover_wait: assert property ($rose(flash_reset_n) |-> flash_oe_n [*6])
    else $error("read before recovery");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response not one cycle");
  c_read: cover property ($fell(flash_oe_n));
  c_write: cover property ($fell(flash_we_n));
  c_accel: cover property (high_program_voltage);
  c_reset: cover property ($rose(flash_reset_n));
endmodule
bind fbc_host fbc_host_assertions chk (.clk(clk), .sys_rst(sys_rst), .rsp_valid(rsp_valid),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_reset_n(flash_reset_n), .protect_accelerate_in(protect_accelerate_in),
  .high_program_voltage(high_program_voltage), .data_lines_oe(data_lines_oe));

// file: fbc_host_bench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ns
module fbc_host_bench;
  import fbc_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, req_word_mode = 1'b1, req_accel = 1'b0;
  logic hv_seen = 1'b0;
  fbc_op_t req_op = FBC_OP_READ;
  logic [21:0] req_addr = 22'h000000;
  logic [15:0] req_wdata = 16'h0000;
  wire req_ready, rsp_valid, rsp_timeout, ce_n, oe_n, we_n, rst_n, wbs, hv, d_oe, rdy_n;
  wire pa_in, lsb_out;
  wire [21:0] f_addr;
  wire [15:0] rsp_rdata, d_out, dev_out;
  wire [15:0] bus = d_oe ? d_out : dev_out;
  int n_errors = 0, comparisons = 0, cyc = 0, n_we = 0;
  fbc_host #(.ADDR_W(22), .READY_WAIT_NS(400)) DUT (.clk(clk), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_word_mode(req_word_mode), .req_accel(req_accel), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_timeout(rsp_timeout),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n),
    .flash_addr(f_addr), .word_byte_select(wbs), .protect_accelerate_in(pa_in),
    .high_program_voltage(hv), .data_lines_out(d_out), .data_lines_oe(d_oe),
    .addr_lsb_out(lsb_out), .data_lines_in(bus), .ready_busy_n(rdy_n));
  fbc_flash_model dev (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
    .addr(f_addr), .wbs(wbs), .din(bus), .dout(dev_out), .ready_busy_n(rdy_n));
  initial forever #4 clk = ~clk;
  always @(negedge we_n) n_we++;
  always @(posedge clk) begin
    if (hv === 1'b1) hv_seen <= 1'b1;
    cyc++;
    // ceiling well above the few hundred cycles the sequence needs
    if (cyc == 60000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic op(input fbc_op_t o, input logic [21:0] a, input logic [15:0] d,
    input logic w, input logic x);
    int i;
    i = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_wdata <= d;
    req_word_mode <= w;
    req_accel <= x;
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && i < 5000) begin
      @(posedge clk);
      i++;
    end
    if (i == 5000) chk(16'hDEAD, 16'h0000);
  endtask
  task automatic t_read(input logic w, input logic [21:0] a);
    logic [15:0] e;
    e = 16'hC350 ^ {12'h000, a[3:0]};
    if (!w) e[15:8] = 8'h00;
    op(FBC_OP_READ, a, 16'h0000, w, 1'b0);
    chk(rsp_rdata, e);
    chk({15'h0000, lsb_out}, {15'h0000, a[0]});
    chk({15'h0000, wbs}, {15'h0000, w});
  endtask
  task automatic t_prog(input logic x, input logic [21:0] a, input logic [15:0] d);
    int i;
    i = 0;
    n_we = 0;
    op(FBC_OP_PROGRAM, a, d, 1'b1, x);
    chk(16'(n_we), x ? 16'h0002 : 16'h0004);
    chk({15'h0000, hv_seen}, {15'h0000, x});
    chk({15'h0000, pa_in}, 16'h0001);
    while (rdy_n !== 1'b1 && i < 200) begin
      @(posedge clk);
      i++;
    end
    op(FBC_OP_READ, a, 16'h0000, 1'b1, 1'b0);
    chk(rsp_rdata, d);
  endtask
  task automatic t_reset();
    op(FBC_OP_RESET, 22'h000000, 16'h0000, 1'b1, 1'b0);
    chk({15'h0000, rsp_timeout}, 16'h0000);
    t_read(1'b1, 22'h000009);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_read(1'b1, 22'h000005);
    t_read(1'b0, 22'h000006);
    t_prog(1'b0, 22'h000003, 16'h1234);
    t_prog(1'b1, 22'h000004, 16'hBEEF);
    t_read(1'b1, 22'h000005);
    t_reset();
    test_done();
  end
endmodule

// file: fbc_pkg.sv
// types for the flash bus host controller
package fbc_pkg;
  typedef enum logic [3:0] {
    FBC_IDLE = 4'b0000,
    FBC_RD_SETUP = 4'b0001,
    FBC_RD_WAIT = 4'b0010,
    FBC_WR_SETUP = 4'b0011,
    FBC_WR_PULSE = 4'b0100,
    FBC_WR_HOLD = 4'b0101,
    FBC_RST_PULSE = 4'b0110,
    FBC_RST_RECOVER = 4'b0111,
    FBC_DONE = 4'b1000
  } fbc_state_t;
  typedef enum logic [1:0] {
    FBC_OP_READ = 2'b00,
    FBC_OP_WRITE = 2'b01,
    FBC_OP_PROGRAM = 2'b10,
    FBC_OP_RESET = 2'b11
  } fbc_op_t;
endpackage

// file: fbc_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module fbc_sync3 #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      dout <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // a change only counts once the second and third stages agree
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end
endmodule
